// [rtc_calendar.sv]
// clock-calendar with pointer windows, write lock and calibration, AXI4-Lite slave
// assumes aclk is the oscillator-derived clock and aresetn is the power-on reset
`include "rtc_consts.svh"

module rtc_calendar #(
    parameter logic [31:0] HALF_SEC_CYCLES = 32'(`RTC_HALF_SEC_NS / `RTC_CLK_PERIOD_NS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_clear_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic calendar_pin,
    output logic calendar_pin_oe
);
    import rtc_pkg::*;

    localparam logic [31:0] THRESH = HALF_SEC_CYCLES + `RTC_BIAS - 32'h0000_0001;

    rtc_state_t s;
    rtc_state_t next_s;
    logic half_tick;
    logic [5:0] ridx;

    function automatic logic [1:0] dec_ptr(input logic [1:0] p);
        dec_ptr = (p == 2'h0) ? 2'h0 : p - 2'h1;
    endfunction

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // years 2000 to 2099 only, so every fourth year is leap
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4] == 1'b0) begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        if (m == 8'h02) begin
            last_day = is_leap(y) ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            last_day = 8'h30;
        end else begin
            last_day = 8'h31;
        end
    endfunction

    // window view selected by pointer
    function automatic logic [15:0] value_view(input logic [1:0] p, input rtc_time_t t);
        case (p)
            2'h0: value_view = {1'b0, t.min[6:0], 1'b0, t.sec[6:0]};
            2'h1: value_view = {5'h00, t.wday, 2'h0, t.hour[5:0]};
            2'h2: value_view = {3'h0, t.mon[4:0], 2'h0, t.day[5:0]};
            default: value_view = {8'h00, t.year};
        endcase
    endfunction

    assign half_tick = s.en && (s.presc >= THRESH);
    assign ridx = araddr[7:2];

    always_comb begin
        next_s = s;
        // timekeeping runs only while en is set
        if (s.en) begin
            next_s.presc = s.presc + 32'h0000_0001;
        end
        if (half_tick) begin
            next_s.presc = `RTC_BIAS;
            next_s.half = ~s.half;
            if (s.half) begin
                // whole second elapsed, BCD ripple
                next_s.tm.sec = bcd_inc(s.tm.sec);
                if (s.tm.sec == 8'h59) begin
                    next_s.tm.sec = 8'h00;
                    next_s.tm.min = bcd_inc(s.tm.min);
                    // calibration applied once a minute, 4 pulses per count
                    next_s.presc = `RTC_BIAS + {{22{s.cal[7]}}, s.cal, 2'h0};
                    if (s.tm.min == 8'h59) begin
                        next_s.tm.min = 8'h00;
                        next_s.tm.hour = bcd_inc(s.tm.hour);
                        if (s.tm.hour == 8'h23) begin
                            next_s.tm.hour = 8'h00;
                            next_s.tm.day = bcd_inc(s.tm.day);
                            next_s.tm.wday = (s.tm.wday == 3'h6) ? 3'h0 : s.tm.wday + 3'h1;
                            if (s.tm.day == last_day(s.tm.mon, s.tm.year)) begin
                                next_s.tm.day = 8'h01;
                                next_s.tm.mon = bcd_inc(s.tm.mon);
                                if (s.tm.mon == 8'h12) begin
                                    next_s.tm.mon = 8'h01;
                                    next_s.tm.year = (s.tm.year == 8'h99) ? 8'h00 :
                                        bcd_inc(s.tm.year);
                                end
                            end
                        end
                    end
                end
            end
        end

        // write channel capture, either order
        if (awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx = awaddr[7:2];
        end
        if (wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata[15:0];
            next_s.wstrb = wstrb[1:0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `RTC_RESP_OKAY;
            // the unlock window spans exactly the next write
            next_s.unlocked = 1'b0;
            next_s.key_seen = 1'b0;
            if (s.aw_idx == `RTC_OFF_CONFIG) begin
                if (s.wstrb[0]) begin
                    next_s.cal = s.wdata[7:0];
                end
                if (s.wstrb[1]) begin
                    next_s.ptr = s.wdata[9:8];
                    next_s.oe = s.wdata[`RTC_BIT_OE];
                    // setting needs the key sequence, clearing never does
                    next_s.wren = s.wdata[`RTC_BIT_WREN] && (s.unlocked || s.wren);
                    if (s.wren) begin
                        next_s.en = s.wdata[`RTC_BIT_EN];
                    end
                end
            end else if (s.aw_idx == `RTC_OFF_VALUE) begin
                if (s.wren) begin
                    case (s.ptr)
                        2'h0: begin
                            if (s.wstrb[0]) begin
                                next_s.tm.sec = {1'b0, s.wdata[6:0]};
                                next_s.half = 1'b0;
                                next_s.presc = `RTC_BIAS;
                            end
                            if (s.wstrb[1]) begin
                                next_s.tm.min = {1'b0, s.wdata[14:8]};
                            end
                        end
                        2'h1: begin
                            if (s.wstrb[0]) begin
                                next_s.tm.hour = {2'h0, s.wdata[5:0]};
                            end
                            if (s.wstrb[1]) begin
                                next_s.tm.wday = s.wdata[10:8];
                            end
                        end
                        2'h2: begin
                            if (s.wstrb[0]) begin
                                next_s.tm.day = {2'h0, s.wdata[5:0]};
                            end
                            if (s.wstrb[1]) begin
                                next_s.tm.mon = {3'h0, s.wdata[12:8]};
                            end
                        end
                        default: begin
                            if (s.wstrb[0]) begin
                                next_s.tm.year = s.wdata[7:0];
                            end
                        end
                    endcase
                end
                if (s.wstrb[1]) begin
                    next_s.ptr = dec_ptr(s.ptr);
                end
            end else if (s.aw_idx == `RTC_OFF_ALARM_CFG) begin
                if (s.wstrb[0]) begin
                    next_s.alarm_cfg[7:0] = s.wdata[7:0];
                end
                if (s.wstrb[1]) begin
                    next_s.alarm_cfg[15:8] = s.wdata[15:8];
                end
            end else if (s.aw_idx == `RTC_OFF_ALARM) begin
                // pointer code 11 stores nothing
                if (s.alarm_cfg[9:8] != 2'h3) begin
                    if (s.wstrb[0]) begin
                        next_s.alarm_val[s.alarm_cfg[9:8]][7:0] = s.wdata[7:0];
                    end
                    if (s.wstrb[1]) begin
                        next_s.alarm_val[s.alarm_cfg[9:8]][15:8] = s.wdata[15:8];
                    end
                end
                if (s.wstrb[1]) begin
                    next_s.alarm_cfg[9:8] = dec_ptr(s.alarm_cfg[9:8]);
                end
            end else if (s.aw_idx == `RTC_OFF_PAD) begin
                if (s.wstrb[0]) begin
                    next_s.out_sel = s.wdata[`RTC_BIT_OSEL];
                end
            end else if (s.aw_idx == `RTC_OFF_UNLOCK) begin
                if (s.wstrb[0]) begin
                    next_s.key_seen = (s.wdata[7:0] == `RTC_KEY1);
                    next_s.unlocked = s.key_seen && (s.wdata[7:0] == `RTC_KEY2);
                end
            end else begin
                next_s.bresp = `RTC_RESP_SLVERR;
            end
        end

        // read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `RTC_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (ridx == `RTC_OFF_CONFIG) begin
                // bit 14 reads zero sync and half are live status
                next_s.rdata[15:0] = {s.en, 1'b0, s.wren, s.sync, s.half, s.oe, s.ptr, s.cal};
            end else if (ridx == `RTC_OFF_VALUE) begin
                next_s.rdata[15:0] = value_view(s.ptr, s.tm);
                next_s.ptr = dec_ptr(s.ptr);
            end else if (ridx == `RTC_OFF_ALARM_CFG) begin
                next_s.rdata[15:0] = s.alarm_cfg;
            end else if (ridx == `RTC_OFF_ALARM) begin
                if (s.alarm_cfg[9:8] != 2'h3) begin
                    next_s.rdata[15:0] = s.alarm_val[s.alarm_cfg[9:8]];
                end
                next_s.alarm_cfg[9:8] = dec_ptr(s.alarm_cfg[9:8]);
            end else if (ridx == `RTC_OFF_PAD) begin
                next_s.rdata[`RTC_BIT_OSEL] = s.out_sel;
            end else if (ridx == `RTC_OFF_UNLOCK) begin
                next_s.rdata[0] = s.unlocked;
            end else begin
                next_s.rresp = `RTC_RESP_SLVERR;
            end
        end

        // a read and a value write in one cycle both decrement once, read wins
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;

        // flag leads the second boundary so a ripple never lands unflagged
        next_s.sync = next_s.en && next_s.half &&
            (next_s.presc >= THRESH - `RTC_SYNC_CYCLES);
        // alarm matching lives elsewhere, so the alarm source is idle low
        next_s.pin = next_s.oe && next_s.out_sel && next_s.half;
        next_s.pin_oe = next_s.oe;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // only this reset touches configuration and time
            s <= '0;
            s.presc <= `RTC_BIAS;
            s.tm.day <= 8'h01;
            s.tm.mon <= 8'h01;
            s.tm.wday <= 3'h6;
        end else if (!master_clear_n) begin
            // core reset clears the bus side only; calendar keeps running
            s <= next_s;
            s.awready <= 1'b0;
            s.wready <= 1'b0;
            s.arready <= 1'b0;
            s.bvalid <= 1'b0;
            s.rvalid <= 1'b0;
            s.aw_held <= 1'b0;
            s.w_held <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign calendar_pin = s.pin;
    assign calendar_pin_oe = s.pin_oe;
endmodule

// [rtc_calendar_asserts.sv]
// port checker of the clock-calendar AXI4-Lite slave
// assumes binding onto rtc_calendar; sees its ports only
`include "rtc_consts.svh"
module rtc_calendar_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic master_clear_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic calendar_pin,
    input wire logic calendar_pin_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    // core reset also clears the handshake, so it gates the checks too
    default disable iff (!aresetn || !master_clear_n);
    sequence s_cfg_read;
        arvalid && arready && araddr[7:2] == 6'h00;
    endsequence
    sequence s_bad_read;
        arvalid && arready && araddr[7:2] > 6'h05;
    endsequence
    a_bresp_stable: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rdata_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    a_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("new write taken while response pending");
    a_bit14_zero: assert property (s_cfg_read |=> rdata[14] == 1'b0)
        else $error("unimplemented config bit reads one");
    a_oe_readback: assert property (s_cfg_read |=> rdata[10] == calendar_pin_oe)
        else $error("pin enable differs from config bit");
    a_pin_quiet: assert property (!calendar_pin_oe |-> !calendar_pin)
        else $error("pin active while output disabled");
    a_unmapped_err: assert property (s_bad_read |=> rresp == `RTC_RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind rtc_calendar rtc_calendar_asserts u_chk (.aclk, .aresetn, .master_clear_n, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .calendar_pin, .calendar_pin_oe);

// [rtc_calendar_tb.sv]
// self-checking bench of the clock-calendar register window
// assumes rtc_calendar with a short half-second count and its bound checker
`include "rtc_consts.svh"
module rtc_calendar_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic master_clear_n = 1'b1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, calendar_pin, calendar_pin_oe;
    logic [1:0] bresp, rresp, r, seen_sync, seen_half, seen_pin;
    logic [31:0] rdata, d, e;
    logic [15:0] rnd [3];
    logic [15:0] vals [4] = '{16'h0025, 16'h0315, 16'h0412, 16'h3045};
    logic [5:0] idx;
    int errors = 0;
    int total_checks = 0;
    int seed = 32'h0def;
    always #20 aclk = ~aclk;
    // 50 cycles a half second keeps a whole minute rollover within reach
    rtc_calendar #(.HALF_SEC_CYCLES(32'h32)) dut (.aclk, .aresetn, .master_clear_n, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .calendar_pin,
        .calendar_pin_oe);
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic hung(input int n);
        if (n >= 200) begin
            errors++;
            $display("wrong value at %0t: bus hang", $time);
            tally_and_finish();
        end
    endtask
    // response ready goes up with the request and stays up until the answer
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 200);
        r = bresp;
        bready <= 1'b0;
        hung(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        hung(n);
    endtask
    task automatic cfg(input logic [15:0] v);
        wr(8'h00, v, 4'h3);
    endtask
    task automatic unlock();
        wr(8'h14, 16'h0055, 4'h1);
        wr(8'h14, 16'h00aa, 4'h1);
    endtask
    // config readback without the two free-running status flags
    function automatic logic [31:0] stable_cfg(input logic [31:0] v);
        return v & 32'hffffe7ff;
    endfunction
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk(stable_cfg(d), 32'h0, "config after reset");
        cfg(16'h0355);
        wr(8'h04, 16'h0099, 4'h3);
        rd(8'h00);
        chk(stable_cfg(d), 32'h0255, "pointer after locked write");
        unlock();
        cfg(16'h2300);
        rd(8'h00);
        chk(stable_cfg(d), 32'h2300, "write enable after unlock");
        for (int k = 0; k < 4; k++) wr(8'h04, vals[k], 4'h3);
        cfg(16'h2300);
        for (int k = 0; k < 5; k++) begin
            rd(8'h04);
            chk(d, {16'h0, vals[k < 4 ? k : 3]}, "value window");
        end
        cfg(16'h2100);
        wr(8'h04, 16'h0013, 4'h1);
        rd(8'h00);
        chk(d[9:8], 2'b01, "pointer after low write");
        rd(8'h04);
        chk(d, 32'h0413, "hours after low write");
        cfg(16'h0000);
        cfg(16'h8000);
        wr(8'h04, 16'h1111, 4'h3);
        rd(8'h04);
        chk(d, 32'h3045, "locked time write");
        rd(8'h00);
        chk(d[15], 1'b0, "enable while locked");
        unlock();
        wr(8'h08, 16'h0000, 4'h3);
        cfg(16'h2000);
        rd(8'h00);
        chk(d[13], 1'b0, "late write enable");
        unlock();
        cfg(16'h2000);
        cfg(16'ha000);
        rd(8'h00);
        chk(d[15], 1'b1, "enable while unlocked");
        $display("lock and value window tests done");
        wr(8'h08, 16'h0200, 4'h3);
        for (int k = 0; k < 3; k++) begin
            rnd[k] = 16'($random(seed));
            wr(8'h0c, rnd[k], 4'h3);
        end
        rd(8'h08);
        chk(d[9:8], 2'b00, "alarm pointer floor");
        wr(8'h08, 16'h0200, 4'h3);
        for (int k = 0; k < 3; k++) begin
            rd(8'h0c);
            chk(d, {16'h0, rnd[k]}, "alarm window");
        end
        wr(8'h08, 16'h0300, 4'h3);
        rd(8'h0c);
        chk(d, 32'h0, "alarm pointer three");
        rd(8'h08);
        chk(d[9:8], 2'b10, "alarm pointer after read");
        for (int k = 0; k < 4; k++) begin
            idx = 6'(32'd6 + {$random(seed)} % 32'd58);
            rd({idx, 2'b00});
            chk(r, `RTC_RESP_SLVERR, "unmapped read");
            wr({idx, 2'b00}, 16'($random(seed)), 4'h3);
            chk(r, `RTC_RESP_SLVERR, "unmapped write");
        end
        $display("alarm and map tests done");
        cfg(16'ha000);
        wr(8'h04, 16'h5958, 4'h3);
        chk(r, `RTC_RESP_OKAY, "seconds write response");
        rd(8'h00);
        chk(d[11], 1'b0, "half flag after seconds write");
        repeat (60) @(posedge aclk);
        rd(8'h00);
        chk(d[11], 1'b1, "half flag second half");
        master_clear_n <= 1'b0;
        repeat (250) @(posedge aclk);
        master_clear_n <= 1'b1;
        repeat (100) @(posedge aclk);
        cfg(16'ha500);
        rd(8'h04);
        chk(d, 32'h0414, "hour after rollover");
        rd(8'h04);
        chk(d, 32'h0002, "minutes seconds after rollover");
        chk(calendar_pin_oe, 1'b1, "pin enable");
        rd(8'h00);
        chk(d[15], 1'b1, "config kept over core reset");
        seen_sync = 2'b00;
        seen_half = 2'b00;
        repeat (40) begin
            rd(8'h00);
            seen_sync[d[12]] = 1'b1;
            seen_half[d[11]] = 1'b1;
        end
        chk(seen_sync, 2'b11, "sync flag both levels");
        chk(seen_half, 2'b11, "half flag both levels");
        for (int k = 1; k >= 0; k--) begin
            wr(8'h10, 16'(k * 2), 4'h3);
            seen_pin = 2'b00;
            repeat (120) begin
                @(posedge aclk);
                seen_pin[calendar_pin] = 1'b1;
            end
            chk(seen_pin, k ? 2'b11 : 2'b01, "pin activity per source");
        end
        cfg(16'ha300);
        wr(8'h04, 16'h0024, 4'h3);
        wr(8'h04, 16'h0228, 4'h3);
        wr(8'h04, 16'h0323, 4'h3);
        wr(8'h04, 16'h5959, 4'h3);
        repeat (110) @(posedge aclk);
        cfg(16'ha200);
        rd(8'h04);
        chk(d, 32'h0229, "leap day after february 28");
        rd(8'h04);
        chk(d, 32'h0400, "weekday after midnight");
        // software side of the ripple guard: read twice, keep matching pair
        for (int k = 0; k < 8; k++) begin
            rd(8'h04);
            e = d;
            rd(8'h04);
            if (d == e) break;
        end
        chk(d, e, "double read agrees");
        cfg(16'h8400);
        rd(8'h00);
        chk(stable_cfg(d), 32'h8400, "write enable dropped, clock kept");
        $display("counting and pin tests done");
        tally_and_finish();
    end
endmodule

// [rtc_consts.svh]
// offsets, field positions, reset values and timing counts of the clock-calendar
// assumes inclusion by its bare name from the design file
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_OFF_CONFIG 6'h00
`define RTC_OFF_VALUE 6'h01
`define RTC_OFF_ALARM_CFG 6'h02
`define RTC_OFF_ALARM 6'h03
`define RTC_OFF_PAD 6'h04
`define RTC_OFF_UNLOCK 6'h05

`define RTC_BIT_EN 15
`define RTC_BIT_WREN 13
`define RTC_BIT_OE 10
`define RTC_BIT_OSEL 1

`define RTC_KEY1 8'h55
`define RTC_KEY2 8'haa

`define RTC_CLK_PERIOD_NS 40
`define RTC_HALF_SEC_NS 500000000
`define RTC_BIAS 32'h0000_0200
`define RTC_SYNC_CYCLES 32'h0000_0020

`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

// [rtc_pkg.sv]
// types of the clock-calendar register window
// takes no number from rtc_consts.svh; every field width is written out here
package rtc_pkg;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [2:0] wday;
        logic [7:0] day;
        logic [7:0] mon;
        logic [7:0] year;
    } rtc_time_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic [5:0] aw_idx;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic en;
        logic wren;
        logic oe;
        logic [1:0] ptr;
        logic [7:0] cal;
        logic half;
        logic sync;
        logic key_seen;
        logic unlocked;
        logic [15:0] alarm_cfg;
        logic [2:0][15:0] alarm_val;
        logic out_sel;
        logic [31:0] presc;
        rtc_time_t tm;
        logic pin;
        logic pin_oe;
    } rtc_state_t;

endpackage
